// *** tap_cmd_pkg.sv ***
// Purpose: shared constants for the tap gain/offset command block
// Assumes: byte-wide command stream, flag in bit 7 of the second byte
// Notes: all offsets, codes, reset values and byte positions live here
package tap_cmd_pkg;

  // command codes of the three settings
  localparam logic [7:0] CMD_LEFT_GAIN = 8'h80;
  localparam logic [7:0] CMD_LEFT_OFFSET = 8'h81;
  localparam logic [7:0] CMD_RIGHT_GAIN = 8'h82;
  localparam logic [7:0] CMD_FIRST = CMD_LEFT_GAIN;
  localparam logic [7:0] CMD_LAST = CMD_RIGHT_GAIN;
  localparam int NUM_SETTINGS = 3;

  // second frame byte: direction flag on top, length below
  localparam int FLAG_BIT = 7;
  localparam logic [6:0] SETTING_LEN = 7'h02;
  localparam logic [7:0] READ_REQUEST = {1'b1, SETTING_LEN};
  localparam logic [7:0] REPLY_FLAG_LEN = {1'b0, SETTING_LEN};

  // settings after reset
  localparam logic [15:0] GAIN_RESET = 16'h0120;
  localparam logic [15:0] OFFSET_RESET = 16'h0000;

  // reply byte positions
  localparam logic [1:0] IDX_CODE = 2'h0;
  localparam logic [1:0] IDX_FLAG_LEN = 2'h1;
  localparam logic [1:0] IDX_LOW = 2'h2;
  localparam logic [1:0] IDX_HIGH = 2'h3;

  // frame parser states
  typedef enum logic [5:0] {
    ST_CODE = 6'b00_0001,
    ST_LEN = 6'b00_0010,
    ST_DATA_LO = 6'b00_0100,
    ST_DATA_HI = 6'b00_1000,
    ST_SKIP = 6'b01_0000,
    ST_REPLY = 6'b10_0000
  } cmd_state_e;

endpackage : tap_cmd_pkg

// *** setting_slot.sv ***
// Purpose: one 16-bit analog front-end setting
// Assumes: write strobe is a single-cycle pulse on clock_i
// Notes: reset value given by parameter
`timescale 1ns/10ps
module setting_slot #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic write_i,
  input wire logic [WIDTH-1:0] wdata_i,
  output logic [WIDTH-1:0] value_o
);

  // width check at elaboration
  if (WIDTH < 1) begin : g_bad_width
    $error("setting_slot: WIDTH must be at least one");
  end

  // holds last accepted write
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      value_o <= RESET_VAL;
    end else if (write_i) begin
      value_o <= wdata_i;
    end
  end

endmodule : setting_slot

// *** tap_gain_offset_commands.sv ***
// Purpose: framed serial commands for left gain, left offset, right gain
// Assumes: bytes arrive on clock_i with valid/ready; same clock as host side
// Notes: frame is code, flag/length byte, then data; reads answered, writes silent
`timescale 1ns/10ps
module tap_gain_offset_commands (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output logic [7:0] tx_byte_o,
  input wire logic tx_ready_i,
  output logic [15:0] left_tap_gain_o,
  output logic [15:0] left_tap_offset_o,
  output logic [15:0] right_tap_gain_o
);

  tap_cmd_pkg::cmd_state_e state;
  tap_cmd_pkg::cmd_state_e next_state;
  logic [7:0] command_code;
  logic [7:0] low_byte;
  logic [6:0] skip_cnt;
  logic [6:0] next_skip_cnt;
  logic [1:0] reply_idx;
  logic [15:0] setting [tap_cmd_pkg::NUM_SETTINGS];

  // handshake and frame decode
  wire rx_fire = rx_valid_i && rx_ready_o;
  wire tx_fire = tx_valid_o && tx_ready_i;
  wire known_code = (command_code >= tap_cmd_pkg::CMD_FIRST) &&
                    (command_code <= tap_cmd_pkg::CMD_LAST);
  wire [7:0] code_delta = command_code - tap_cmd_pkg::CMD_FIRST;
  wire [1:0] sel = code_delta[1:0];
  wire rx_flag = rx_byte_i[tap_cmd_pkg::FLAG_BIT];
  wire [6:0] rx_len = rx_byte_i[6:0];
  wire len_ok = (rx_len == tap_cmd_pkg::SETTING_LEN);
  wire read_ok = known_code && rx_flag && len_ok;
  wire write_ok = known_code && !rx_flag && len_ok;
  wire write_stb = (state == tap_cmd_pkg::ST_DATA_HI) && rx_fire;

  // no new bytes taken while a reply is going out
  assign rx_ready_o = (state != tap_cmd_pkg::ST_REPLY);
  assign tx_valid_o = (state == tap_cmd_pkg::ST_REPLY);

  // the three settings, one slot each
  for (genvar i = 0; i < tap_cmd_pkg::NUM_SETTINGS; i++) begin : g_slot
    setting_slot #(
      .WIDTH(16),
      .RESET_VAL(i == 1 ? tap_cmd_pkg::OFFSET_RESET : tap_cmd_pkg::GAIN_RESET)
    ) u_slot (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .write_i(write_stb && (sel == 2'(i))),
      .wdata_i({rx_byte_i, low_byte}),
      .value_o(setting[i])
    );
  end

  assign left_tap_gain_o = setting[0];
  assign left_tap_offset_o = setting[1];
  assign right_tap_gain_o = setting[2];

  // reply byte chosen by position; value of selected setting
  wire [15:0] read_val = (sel == 2'h0) ? setting[0] :
                         (sel == 2'h1) ? setting[1] : setting[2];
  wire [1:0] next_idx = reply_idx + 2'h1;
  wire [7:0] reply_byte = (next_idx == tap_cmd_pkg::IDX_FLAG_LEN) ?
                          tap_cmd_pkg::REPLY_FLAG_LEN :
                          (next_idx == tap_cmd_pkg::IDX_LOW) ? read_val[7:0] :
                          read_val[15:8];

  // frame parser next state
  always_comb begin
    next_state = state;
    next_skip_cnt = skip_cnt;
    case (state)
      tap_cmd_pkg::ST_CODE: begin
        if (rx_fire) begin
          next_state = tap_cmd_pkg::ST_LEN;
        end
      end
      tap_cmd_pkg::ST_LEN: begin
        if (rx_fire) begin
          if (read_ok) begin
            next_state = tap_cmd_pkg::ST_REPLY;
          end else if (rx_flag || rx_len == 7'h00) begin
            next_state = tap_cmd_pkg::ST_CODE;
          end else if (write_ok) begin
            next_state = tap_cmd_pkg::ST_DATA_LO;
          end else begin
            next_state = tap_cmd_pkg::ST_SKIP;
            next_skip_cnt = rx_len;
          end
        end
      end
      tap_cmd_pkg::ST_DATA_LO: begin
        if (rx_fire) begin
          next_state = tap_cmd_pkg::ST_DATA_HI;
        end
      end
      tap_cmd_pkg::ST_DATA_HI: begin
        if (rx_fire) begin
          next_state = tap_cmd_pkg::ST_CODE;
        end
      end
      tap_cmd_pkg::ST_SKIP: begin
        if (rx_fire) begin
          next_skip_cnt = skip_cnt - 7'h01;
          if (skip_cnt == 7'h01) begin
            next_state = tap_cmd_pkg::ST_CODE;
          end
        end
      end
      tap_cmd_pkg::ST_REPLY: begin
        if (tx_fire && reply_idx == tap_cmd_pkg::IDX_HIGH) begin
          next_state = tap_cmd_pkg::ST_CODE;
        end
      end
      default: begin
        next_state = tap_cmd_pkg::ST_CODE;
      end
    endcase
  end

  // state and counters
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= tap_cmd_pkg::ST_CODE;
      skip_cnt <= 7'h00;
    end else begin
      state <= next_state;
      skip_cnt <= next_skip_cnt;
    end
  end

  // captured frame bytes
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      command_code <= 8'h00;
      low_byte <= 8'h00;
    end else begin
      if (rx_fire && state == tap_cmd_pkg::ST_CODE) begin
        command_code <= rx_byte_i;
      end
      if (rx_fire && state == tap_cmd_pkg::ST_DATA_LO) begin
        low_byte <= rx_byte_i;
      end
    end
  end

  // reply serializer: code, flag/length, low, high
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      reply_idx <= tap_cmd_pkg::IDX_CODE;
      tx_byte_o <= 8'h00;
    end else if (state == tap_cmd_pkg::ST_LEN && rx_fire && read_ok) begin
      reply_idx <= tap_cmd_pkg::IDX_CODE;
      tx_byte_o <= command_code;
    end else if (tx_fire) begin
      reply_idx <= next_idx;
      tx_byte_o <= reply_byte;
    end
  end

  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  wire in_len = (state == tap_cmd_pkg::ST_LEN) && rx_fire;
  wire low_out = tx_fire && reply_idx == tap_cmd_pkg::IDX_LOW;

  property p_lgain_reply;
    in_len && command_code == tap_cmd_pkg::CMD_LEFT_GAIN &&
    rx_byte_i == tap_cmd_pkg::READ_REQUEST |=> tx_valid_o &&
    tx_byte_o == tap_cmd_pkg::CMD_LEFT_GAIN;
  endproperty
  a_lgain_reply: assert property (p_lgain_reply) else $error("left gain reply header wrong");

  // second reply byte always flag 0 with length 2
  property p_flag_len;
    tx_fire && reply_idx == tap_cmd_pkg::IDX_CODE |=>
    tx_byte_o == tap_cmd_pkg::REPLY_FLAG_LEN;
  endproperty
  a_flag_len: assert property (p_flag_len) else $error("reply flag or length wrong");

  property p_loff_reply;
    in_len && command_code == tap_cmd_pkg::CMD_LEFT_OFFSET &&
    rx_byte_i == tap_cmd_pkg::READ_REQUEST |=> tx_valid_o &&
    tx_byte_o == tap_cmd_pkg::CMD_LEFT_OFFSET;
  endproperty
  a_loff_reply: assert property (p_loff_reply) else $error("left offset reply code wrong");

  property p_rgain_reply;
    in_len && command_code == tap_cmd_pkg::CMD_RIGHT_GAIN &&
    rx_byte_i == tap_cmd_pkg::READ_REQUEST |=> tx_valid_o &&
    tx_byte_o == tap_cmd_pkg::CMD_RIGHT_GAIN;
  endproperty
  a_rgain_reply: assert property (p_rgain_reply) else $error("right gain reply code wrong");

  property p_write_silent;
    write_stb |=> !tx_valid_o ##1 !tx_valid_o;
  endproperty
  a_write_silent: assert property (p_write_silent) else $error("reply after write");

  property p_lgain_order;
    low_out && command_code == tap_cmd_pkg::CMD_LEFT_GAIN |->
    tx_byte_o == left_tap_gain_o[7:0] ##1 tx_byte_o == $past(left_tap_gain_o[15:8]);
  endproperty
  a_lgain_order: assert property (p_lgain_order) else $error("left gain byte order wrong");

  property p_loff_low;
    tx_valid_o && reply_idx == tap_cmd_pkg::IDX_LOW &&
    command_code == tap_cmd_pkg::CMD_LEFT_OFFSET |-> tx_byte_o == left_tap_offset_o[7:0];
  endproperty
  a_loff_low: assert property (p_loff_low) else $error("left offset low byte wrong");

  property p_rgain_high;
    tx_valid_o && reply_idx == tap_cmd_pkg::IDX_HIGH &&
    command_code == tap_cmd_pkg::CMD_RIGHT_GAIN |-> tx_byte_o == right_tap_gain_o[15:8];
  endproperty
  a_rgain_high: assert property (p_rgain_high) else $error("right gain high byte wrong");

  property p_store;
    write_stb && command_code == tap_cmd_pkg::CMD_LEFT_GAIN |=>
    left_tap_gain_o == {$past(rx_byte_i), $past(low_byte)};
  endproperty
  a_store: assert property (p_store) else $error("left gain not stored");

  c_read: cover property (in_len && read_ok ##1 tx_fire [*4]);
  c_write: cover property (write_stb);
  c_skip: cover property (state == tap_cmd_pkg::ST_SKIP && rx_fire);

endmodule : tap_gain_offset_commands

// *** host_model.sv ***
// Purpose: host side of the command link, sends frames and takes replies
// Assumes: tasks are entered just after a rising edge of clock_i
// Notes: idle data line shows the inverted last byte; hung_o marks a stall
`timescale 1ns/10ps
module host_model (
  input wire logic clock_i,
  input wire logic rx_ready_i,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_byte_i,
  output logic rx_valid_o,
  output logic [7:0] rx_byte_o,
  output logic tx_ready_o,
  output logic hung_o
);
  int seed = 34122;

  // quiet lines at time zero
  initial begin
    rx_valid_o = 1'b0;
    rx_byte_o = 8'h00;
    tx_ready_o = 1'b0;
    hung_o = 1'b0;
  end

  // offer one byte, hold it until taken
  task automatic put(input logic [7:0] b);
    logic took;
    rx_valid_o <= 1'b1;
    rx_byte_o <= b;
    for (int n = 0; n < 64; n++) begin
      @(posedge clock_i);
      took = rx_ready_i;
      if (took) break;
    end
    if (!took) hung_o <= 1'b1;
  endtask : put

  // drop valid, scramble the data line
  task automatic idle();
    rx_valid_o <= 1'b0;
    rx_byte_o <= ~rx_byte_o;
  endtask : idle

  // write frame: code, flag 0 with length 2, low byte, high byte
  task automatic wr(input logic [7:0] code, input logic [15:0] val);
    put(code);
    put(8'h02);
    put(val[7:0]);
    put(val[15:8]);
  endtask : wr

  // read frame, then take four reply bytes with random stalls
  task automatic rd(input logic [7:0] code, output logic [31:0] got);
    logic took;
    put(code);
    put(8'h82);
    idle();
    for (int i = 0; i < 4; i++) begin
      took = 1'b0;
      for (int n = 0; n < 64 && !took; n++) begin
        tx_ready_o <= ($random(seed) & 32'h0000_0003) != 0;
        @(posedge clock_i);
        took = tx_valid_i && tx_ready_o;
      end
      if (!took) hung_o <= 1'b1;
      got[8*i +: 8] = tx_byte_i;
    end
    tx_ready_o <= 1'b0;
  endtask : rd
endmodule : host_model

// *** tap_gain_offset_commands_test.sv ***
// Purpose: self-checking bench for the tap gain/offset command block
// Assumes: host_model drives the link; expectations kept in a shadow copy
// Notes: reset values first, then corner values, an unknown code, then random in-range writes and reads
`timescale 1ns/10ps
module tap_gain_offset_commands_test;
  logic clock_i, rst_i, rx_valid, rx_ready, tx_valid, tx_ready, hung;
  logic [7:0] rx_byte, tx_byte;
  logic [15:0] lgain, loff, rgain;
  logic [15:0] shadow [3];
  logic [15:0] corner [6] = '{16'h0120, 16'h0239, 16'h0000, 16'h00FF, 16'h0239, 16'h0120};
  int failures = 0, n_compared = 0, takes = 0, seed = 34122;

  tap_gain_offset_commands tap_gain_offset_commands_inst (.clock_i(clock_i), .rst_i(rst_i),
    .rx_valid_i(rx_valid), .rx_byte_i(rx_byte), .rx_ready_o(rx_ready), .tx_valid_o(tx_valid),
    .tx_byte_o(tx_byte), .tx_ready_i(tx_ready), .left_tap_gain_o(lgain),
    .left_tap_offset_o(loff), .right_tap_gain_o(rgain));
  host_model host_model_inst (.clock_i(clock_i), .rx_ready_i(rx_ready), .tx_valid_i(tx_valid),
    .tx_byte_i(tx_byte), .rx_valid_o(rx_valid), .rx_byte_o(rx_byte), .tx_ready_o(tx_ready),
    .hung_o(hung));

  // clock source
  initial begin
    clock_i = 1'b0;
    forever #4 clock_i = ~clock_i;
  end

  // count reply bytes taken at the falling edge, where handshake lines are settled
  always @(negedge clock_i) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) takes++;
    if (hung === 1'b1) begin
      failures++;
      complete_run();
    end
  end

  // expected reply: code, flag 0 with length 2, low, high
  function automatic logic [31:0] reply(input logic [7:0] code, input logic [15:0] v);
    return {v[15:8], v[7:0], 8'h02, code};
  endfunction : reply

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : check

  // read one setting, compare reply, stored outputs and reply count
  task automatic rd_chk(input int idx, input int t0);
    logic [31:0] got;
    host_model_inst.rd(8'h80 + 8'(idx), got);
    check("reply", got, reply(8'h80 + 8'(idx), shadow[idx]));
    check("left gain", {16'h0000, lgain}, {16'h0000, shadow[0]});
    check("left offset", {16'h0000, loff}, {16'h0000, shadow[1]});
    check("right gain", {16'h0000, rgain}, {16'h0000, shadow[2]});
    check("reply bytes", takes - t0, 4);
  endtask : rd_chk

  // write then read back at once, no gap between frames
  task automatic wr_chk(input int idx, input logic [15:0] v);
    int t0;
    t0 = takes;
    host_model_inst.wr(8'h80 + 8'(idx), v);
    shadow[idx] = v;
    rd_chk(idx, t0);
  endtask : wr_chk

  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run

  // main sequence
  initial begin
    int idx;
    int t0;
    logic [15:0] v;
    rst_i = 1'b1;
    shadow = '{16'h0120, 16'h0000, 16'h0120};
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 3; i++) rd_chk(i, takes);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) wr_chk(i / 2, corner[i]);
    $display("test range corners done");
    // unknown code: data bytes skipped, no reply, settings untouched
    t0 = takes;
    host_model_inst.wr(8'h83, 16'h5A5A);
    rd_chk(0, t0);
    $display("test unknown code done");
    for (int i = 0; i < 40; i++) begin
      idx = ($random(seed) & 32'h7FFF_FFFF) % 3;
      v = 16'(($random(seed) & 32'h7FFF_FFFF) % 282 + 288);
      if (idx == 1) v = 16'($random(seed) & 32'h0000_00FF);
      wr_chk(idx, v);
      rd_chk((idx + 1) % 3, takes);
    end
    $display("test random traffic done");
    complete_run();
  end
endmodule : tap_gain_offset_commands_test
